// ==== rtl/rtsm_pkg.sv ====
// Package for the resistive touch switch matrix: register map, fields, encodings
package rtsm_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_ST = 8'h08;
  localparam logic [7:0] ADDR_INT_MK = 8'h0c;

  // Control register field positions
  localparam int CTRL_PX_PWR  = 0;
  localparam int CTRL_PX_GND  = 1;
  localparam int CTRL_MX_PWR  = 2;
  localparam int CTRL_MX_GND  = 3;
  localparam int CTRL_PY_PWR  = 4;
  localparam int CTRL_PY_GND  = 5;
  localparam int CTRL_MY_PWR  = 6;
  localparam int CTRL_MY_GND  = 7;
  localparam int CTRL_FALL_EN = 8;
  localparam int CTRL_RISE_EN = 9;
  localparam int CTRL_MODE_LO = 10;
  localparam int CTRL_BIAS_EN = 12;
  localparam int CTRL_SEL_LO  = 13;
  localparam int CTRL_STANDBY = 15;
  localparam int CTRL_WIDTH   = 16;

  // Interrupt status bit positions
  localparam int INT_PRESS   = 0;
  localparam int INT_RELEASE = 1;
  localparam int INT_WIDTH   = 2;

  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0]  INT_RESET  = 2'h0;

  // Touch mode field encodings
  typedef enum logic [1:0] {
    RTSM_MODE_INTR  = 2'b00,
    RTSM_MODE_PRESS = 2'b01,
    RTSM_MODE_POSA  = 2'b10,
    RTSM_MODE_POSB  = 2'b11
  } rtsm_mode_t;

  // Converter input routing
  typedef enum logic [2:0] {
    RTSM_ADC_XP  = 3'b000,
    RTSM_ADC_XM  = 3'b001,
    RTSM_ADC_YP  = 3'b010,
    RTSM_ADC_YM  = 3'b011,
    RTSM_ADC_CUR = 3'b100
  } rtsm_adc_t;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/rtsm_top.sv ====
// Resistive touch switch matrix control with AXI4-Lite registers and touch interrupts
`timescale 1ns/100ps
`default_nettype none

module rtsm_top (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Filtered threshold detector outputs of the two X terminals
  input  wire logic        x_plus_detect,
  input  wire logic        x_minus_detect,
  // Switch matrix drive, one bit per terminal: plus X, minus X, plus Y, minus Y
  output logic [3:0]       terminal_power_on,
  output logic [3:0]       terminal_ground_on,
  // Bias and converter routing
  output logic             bias_resistor_on,
  output logic             bias_circuit_on,
  output logic [2:0]       adc_input_route,
  output logic             touch_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses, one 32-bit word each
  //   0x00 control, read/write, low 16 bits used:
  //     [0] plus X power    [1] plus X ground
  //     [2] minus X power   [3] minus X ground
  //     [4] plus Y power    [5] plus Y ground
  //     [6] minus Y power   [7] minus Y ground
  //     [8]     press interrupt enable, detector falling edge
  //     [9]     release interrupt enable, detector rising edge
  //     [11:10] touch_mode_field: 00 interrupt, 01 pressure, 1x position
  //     [12]    active bias enable; ignored in interrupt mode, where the active bias stays off
  //     [14:13] converter terminal select
  //     [15]    standby: only the active bias circuit is switched off
  //   0x04 status, read only, writes are ignored with OKAY:
  //     [3:0] effective ground, [6] resistor bias, [7] active bias
  //     [10:8] converter route, [11] synchronised detector level
  //   0x08 interrupt status, [0] press, [1] release
  //     Write one to clear; an event in the same cycle beats the clear
  //   0x0c interrupt mask, same layout as the status
  //   Other addresses answer SLVERR; reads return zero, writes change nothing

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0]  int_st;
    logic [1:0]  int_mk;
    logic [1:0]  xp_sync;
    logic [1:0]  xm_sync;
    logic        det_prev;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  pwr;
    logic [3:0]  gnd;
    logic        bias_res;
    logic        bias_cir;
    logic [2:0]  route;
    logic        irq;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } rtsm_state_t;

  rtsm_state_t st_q;
  rtsm_state_t st_d;

  logic [3:0]  pwr_req;
  logic [3:0]  gnd_req;
  logic        det_now;
  logic        det_fall;
  logic        det_rise;
  logic [1:0]  int_set;
  logic [1:0]  int_clr;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [1:0]  mode;

  ////////////////////////////////////////////////////////////////////////////
  // Switch matrix requests per terminal

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_term
      assign pwr_req[gi] = st_q.ctrl[2 * gi];
      assign gnd_req[gi] = st_q.ctrl[2 * gi + 1];
    end
  endgenerate

  // Write strobes expand to a bit mask
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[8 * gi +: 8] = {8{st_q.w_strb[gi]}};
    end
  endgenerate

  // Status bit positions, declared before the edge logic that indexes them
  localparam int INT_PRESS_I   = rtsm_pkg::INT_PRESS;
  localparam int INT_RELEASE_I = rtsm_pkg::INT_RELEASE;

  // Detector: low on either X terminal means pressed; second sync stage only
  // The first stage may still be settling, so nothing else reads it
  assign det_now  = st_q.xp_sync[1] & st_q.xm_sync[1];
  assign det_fall = st_q.det_prev & ~det_now;
  assign det_rise = ~st_q.det_prev & det_now;
  // Edge detection runs regardless of standby, so the irq can wake the system
  assign int_set[INT_PRESS_I]   = det_fall & st_q.ctrl[rtsm_pkg::CTRL_FALL_EN];
  assign int_set[INT_RELEASE_I] = det_rise & st_q.ctrl[rtsm_pkg::CTRL_RISE_EN];

  assign mode = st_q.ctrl[rtsm_pkg::CTRL_MODE_LO +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign wr_fire = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
  assign rd_fire = s_axi_arvalid & ~st_q.rvalid;

  // Read mux; unmapped addresses answer SLVERR with zero data
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      rtsm_pkg::ADDR_CTRL:   rd_val = {16'h0000, st_q.ctrl};
      rtsm_pkg::ADDR_STATUS: rd_val = {20'h00000, det_now, st_q.route, st_q.bias_cir, st_q.bias_res,
                                       2'h0, st_q.gnd};
      rtsm_pkg::ADDR_INT_ST: rd_val = {30'h0000_0000, st_q.int_st};
      rtsm_pkg::ADDR_INT_MK: rd_val = {30'h0000_0000, st_q.int_mk};
      default:               rd_ok  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d    = st_q;
    int_clr = 2'h0;

    // Synchronise the detector pins, two flops each
    st_d.xp_sync  = {st_q.xp_sync[0], x_plus_detect};
    st_d.xm_sync  = {st_q.xm_sync[0], x_minus_detect};
    st_d.det_prev = det_now;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = rtsm_pkg::RESP_OKAY;
      case (st_q.aw_addr)
        rtsm_pkg::ADDR_CTRL:
          st_d.ctrl = (st_q.ctrl & ~wmask[15:0]) | (st_q.w_data[15:0] & wmask[15:0]);
        rtsm_pkg::ADDR_STATUS: ;
        rtsm_pkg::ADDR_INT_ST:
          int_clr = st_q.w_data[1:0] & wmask[1:0];
        rtsm_pkg::ADDR_INT_MK:
          st_d.int_mk = (st_q.int_mk & ~wmask[1:0]) | (st_q.w_data[1:0] & wmask[1:0]);
        default:
          st_d.bresp = rtsm_pkg::RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Read answers one cycle after the address is taken
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_val;
      st_d.rresp  = rd_ok ? rtsm_pkg::RESP_OKAY : rtsm_pkg::RESP_SLVERR;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end

    // Sticky status: a new event wins over a simultaneous clear
    st_d.int_st = (st_q.int_st & ~int_clr) | int_set;
    st_d.irq    = |(st_d.int_st & st_d.int_mk);

    // Conflict resolution: ground dominates, power only if not grounded
    st_d.gnd = gnd_req;
    st_d.pwr = pwr_req & ~gnd_req;

    // Mode decodes bias source and converter routing
    case (mode)
      rtsm_pkg::RTSM_MODE_INTR: begin
        st_d.bias_res = 1'b1;
        st_d.bias_cir = 1'b0;
        st_d.route    = {1'b0, st_q.ctrl[rtsm_pkg::CTRL_SEL_LO +: 2]};
      end
      rtsm_pkg::RTSM_MODE_PRESS: begin
        st_d.bias_res = 1'b0;
        st_d.bias_cir = st_q.ctrl[rtsm_pkg::CTRL_BIAS_EN] & ~st_q.ctrl[rtsm_pkg::CTRL_STANDBY];
        st_d.route    = rtsm_pkg::RTSM_ADC_CUR;
      end
      default: begin
        st_d.bias_res = 1'b0;
        st_d.bias_cir = st_q.ctrl[rtsm_pkg::CTRL_BIAS_EN] & ~st_q.ctrl[rtsm_pkg::CTRL_STANDBY];
        st_d.route    = {1'b0, st_q.ctrl[rtsm_pkg::CTRL_SEL_LO +: 2]};
      end
    endcase

    // Ready flags come from flops; each is the inverse of its holding flag
    // so the bus outputs need no gate after the register
    st_d.aw_rdy = ~st_d.aw_got;
    st_d.w_rdy  = ~st_d.w_got;
    st_d.ar_rdy = ~st_d.rvalid;

    if (sys_rst) begin
      st_d = '0;
      st_d.ctrl   = rtsm_pkg::CTRL_RESET;
      st_d.int_st = rtsm_pkg::INT_RESET;
      st_d.int_mk = rtsm_pkg::INT_RESET;
      st_d.xp_sync = 2'h3;
      st_d.xm_sync = 2'h3;
      st_d.det_prev = 1'b1;
      st_d.bias_res = 1'b1;
      st_d.aw_rdy   = 1'b1;
      st_d.w_rdy    = 1'b1;
      st_d.ar_rdy   = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign s_axi_awready      = st_q.aw_rdy;
  assign s_axi_wready       = st_q.w_rdy;
  assign s_axi_bvalid       = st_q.bvalid;
  assign s_axi_bresp        = st_q.bresp;
  assign s_axi_arready      = st_q.ar_rdy;
  assign s_axi_rvalid       = st_q.rvalid;
  assign s_axi_rdata        = st_q.rdata;
  assign s_axi_rresp        = st_q.rresp;
  assign terminal_power_on  = st_q.pwr;
  assign terminal_ground_on = st_q.gnd;
  assign bias_resistor_on   = st_q.bias_res;
  assign bias_circuit_on    = st_q.bias_cir;
  assign adc_input_route    = st_q.route;
  assign touch_irq          = st_q.irq;

endmodule

`default_nettype wire

// ==== dv/rtsm_top_asserts.sv ====
// Port-level checks for the touch switch matrix block
`timescale 1ns/100ps
`default_nettype none
module rtsm_top_asserts (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  terminal_power_on,
  input wire logic [3:0]  terminal_ground_on,
  input wire logic        bias_resistor_on,
  input wire logic        bias_circuit_on,
  input wire logic [2:0]  adc_input_route,
  input wire logic        touch_irq
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Switch matrix and routing
  chk_no_conflict: assert property ((terminal_power_on & terminal_ground_on) == 4'h0)
    else $error("Terminal powered and grounded together");
  chk_bias_source: assert property (!(bias_resistor_on && bias_circuit_on))
    else $error("Both bias sources on");
  chk_route_cur: assert property (adc_input_route == 3'h4 |-> !bias_resistor_on)
    else $error("Current monitor routed in resistor bias");
  chk_route_range: assert property (adc_input_route <= 3'h4)
    else $error("Converter route out of range");
  chk_reset_state: assert property ($fell(sys_rst) |-> bias_resistor_on && !touch_irq && terminal_power_on == 4'h0)
    else $error("Wrong state after reset");
  ////////////////////////////////////////
  // Register bus answers and holds
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("Write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read response late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken while busy");
  // Main scenarios reached
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(touch_irq));
endmodule
bind rtsm_top rtsm_top_asserts u_chk (.core_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .terminal_power_on, .terminal_ground_on, .bias_resistor_on,
  .bias_circuit_on, .adc_input_route, .touch_irq);
`default_nettype wire

// ==== dv/rtsm_panel_model.sv ====
// Behavioural four-wire resistive panel seen through the filtered X detectors
`timescale 1ns/100ps
`default_nettype none
module rtsm_panel_model (
  input wire logic [3:0] terminal_power_on,
  input wire logic [3:0] terminal_ground_on,
  input wire logic       pressed,
  output logic           x_plus_detect,
  output logic           x_minus_detect
);
  // A powered X terminal reads high until a press shorts it to a grounded Y plate
  // An unpowered X plate has no pull-up, so its detector reads low
  assign x_plus_detect = terminal_power_on[0] & ~(pressed & |terminal_ground_on[3:2]);
  assign x_minus_detect = terminal_power_on[1] & ~(pressed & |terminal_ground_on[3:2]);
endmodule
`default_nettype wire

// ==== dv/test_rtsm_top.sv ====
// Self-checking testbench for the touch switch matrix block
`timescale 1ns/100ps
`default_nettype none
module test_rtsm_top;
  logic core_clk = 1'b0, sys_rst = 1'b1, pressed = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, terminal_power_on, terminal_ground_on;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, touch_irq;
  logic x_plus_detect, x_minus_detect, bias_resistor_on, bias_circuit_on;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] adc_input_route;
  int error_cnt = 0, samples_checked = 0;
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  rtsm_top u_dut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .x_plus_detect, .x_minus_detect,
    .terminal_power_on, .terminal_ground_on, .bias_resistor_on, .bias_circuit_on, .adc_input_route, .touch_irq);
  rtsm_panel_model u_panel (.terminal_power_on, .terminal_ground_on, .pressed, .x_plus_detect, .x_minus_detect);
  ////////////////////////////////////////
  // Comparison, verdict and bounded waits
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A wait that used up its bound counts as a mismatch and stops the run
  task automatic guard(input int n);
    if (n >= 50) begin
      check(32'h0, 32'h1);
      end_of_test();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  // Register bus master, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    guard(n);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    guard(n);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check({terminal_power_on, terminal_ground_on, adc_input_route}, 32'h0);
    check({bias_resistor_on, bias_circuit_on, touch_irq}, 32'h4);
    rd(rtsm_pkg::ADDR_CTRL, 32'h0, rtsm_pkg::RESP_OKAY);
    rd(rtsm_pkg::ADDR_INT_MK, 32'h0, rtsm_pkg::RESP_OKAY);
    rd(8'h10, 32'h0, rtsm_pkg::RESP_SLVERR);
    wr(8'h10, 32'hffff, rtsm_pkg::RESP_SLVERR);
    $display("Test reset done");
  endtask
  // Each terminal powered alone, then powered and grounded at once
  task automatic t_matrix();
    for (int i = 0; i < 4; i++) begin
      wr(rtsm_pkg::ADDR_CTRL, 32'h1 << (2 * i), rtsm_pkg::RESP_OKAY);
      cyc(2);
      check({terminal_power_on, terminal_ground_on}, 32'h10 << i);
      wr(rtsm_pkg::ADDR_CTRL, 32'h3 << (2 * i), rtsm_pkg::RESP_OKAY);
      cyc(2);
      check({terminal_power_on, terminal_ground_on}, 32'h1 << i);
    end
    $display("Test matrix done");
  endtask
  // Every mode code with terminal 2 selected, then every select in position mode
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(rtsm_pkg::ADDR_CTRL, (m << 10) | 32'h5000, rtsm_pkg::RESP_OKAY);
      cyc(2);
      check({bias_resistor_on, bias_circuit_on}, (m == 0) ? 32'h2 : 32'h1);
      check(adc_input_route, (m == 1) ? 32'h4 : 32'h2);
    end
    for (int s = 0; s < 4; s++) begin
      wr(rtsm_pkg::ADDR_CTRL, (s << 13) | 32'h0800, rtsm_pkg::RESP_OKAY);
      cyc(2);
      check(adc_input_route, s);
    end
    $display("Test modes done");
  endtask
  // Program the control word, then compare switch matrix, route and bias sources
  task automatic set_chk(input logic [31:0] c, input logic [7:0] pg, input logic [2:0] rt, input logic [1:0] bs);
    wr(rtsm_pkg::ADDR_CTRL, c, rtsm_pkg::RESP_OKAY);
    cyc(2);
    check({terminal_power_on, terminal_ground_on}, pg);
    check(adc_input_route, rt);
    check({bias_resistor_on, bias_circuit_on}, bs);
  endtask
  // Host sequences: a pressure frame after each plate change, then position
  task automatic t_measure();
    set_chk(32'h0000_1490, 8'h48, 3'h4, 2'h1);
    set_chk(32'h0000_1890, 8'h48, 3'h0, 2'h1);
    set_chk(32'h0000_1409, 8'h12, 3'h4, 2'h1);
    set_chk(32'h0000_5809, 8'h12, 3'h2, 2'h1);
    set_chk(32'h0000_14a5, 8'h3c, 3'h4, 2'h1);
    rd(rtsm_pkg::ADDR_STATUS, 32'h0000_0c8c, rtsm_pkg::RESP_OKAY);
    set_chk(32'h0000_9409, 8'h12, 3'h4, 2'h0);
    $display("Test measure done");
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (touch_irq !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    guard(n);
  endtask
  // Standby, both edges enabled, active bias left off, X powered and Y grounded
  task automatic t_irq();
    wr(rtsm_pkg::ADDR_CTRL, 32'h83a5, rtsm_pkg::RESP_OKAY);
    cyc(8);
    wr(rtsm_pkg::ADDR_INT_ST, 32'h3, rtsm_pkg::RESP_OKAY);
    wr(rtsm_pkg::ADDR_INT_MK, 32'h3, rtsm_pkg::RESP_OKAY);
    pressed <= 1'b1;
    wait_irq();
    rd(rtsm_pkg::ADDR_INT_ST, 32'h1, rtsm_pkg::RESP_OKAY);
    wr(rtsm_pkg::ADDR_INT_ST, 32'h1, rtsm_pkg::RESP_OKAY);
    cyc(2);
    check(touch_irq, 32'h0);
    pressed <= 1'b0;
    wait_irq();
    rd(rtsm_pkg::ADDR_INT_ST, 32'h2, rtsm_pkg::RESP_OKAY);
    // Release edge disabled and press masked: the status stays sticky, no output
    wr(rtsm_pkg::ADDR_CTRL, 32'h81a5, rtsm_pkg::RESP_OKAY);
    wr(rtsm_pkg::ADDR_INT_ST, 32'h3, rtsm_pkg::RESP_OKAY);
    wr(rtsm_pkg::ADDR_INT_MK, 32'h2, rtsm_pkg::RESP_OKAY);
    pressed <= 1'b1;
    cyc(10);
    pressed <= 1'b0;
    cyc(10);
    check(touch_irq, 32'h0);
    rd(rtsm_pkg::ADDR_INT_ST, 32'h1, rtsm_pkg::RESP_OKAY);
    $display("Test interrupt done");
  endtask
  ////////////////////////////////////////
  // Main sequence: reset held for 10 cycles, then every scenario
  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    cyc(1);
    t_reset();
    t_matrix();
    t_modes();
    t_measure();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
